// *** verif/smc_sensor_model.sv ***
`timescale 1ns/1ps

// contact sensors: a closed contact returns its own test pulse, an open
// one is pulled low, so no stale level survives a release
module smc_sensor_model (
    // contact states and pulse drive
    input  wire logic [3:0] closed_in,
    input  wire logic [3:0] pulse_in,
    // levels seen at the controller pins
    output logic      [3:0] sensor_out
);
    // separate wiring per channel keeps the pairs redundant
    assign sensor_out = closed_in & pulse_in;
endmodule : smc_sensor_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    logic        sys_clk_in;
    logic        rst_n_in;
    logic [3:0]  addr_in;
    logic [15:0] wr_data_in;
    logic        wr_en_in;
    logic        rd_en_in;
    logic [15:0] rd_data_out;
    logic [3:0]  sensor_in;
    logic [3:0]  closed;
    logic [3:0]  pulse;
    logic        permit;
    logic        guard_in;
    logic        ind;
    logic        safe;
    logic        stop;
    logic        lamp_cut;
    logic        sa;
    logic        sb;
    logic        flt;
    logic        rd_pend;
    logic [15:0] exp_q[$];
    logic [15:0] lim;
    int          n_errors;
    int          cmp_count;
    int          seed;

    smc_mute_ctrl #(.TICK_CYCLES(10), .PULSE_CYCLES(8)) dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .sensor_in(sensor_in),
        .mute_permit_input_in(permit), .test_pulse_out(pulse),
        .guard_in(guard_in), .stop_req_in(stop), .lockout_in(1'b0),
        .system_reset_in(1'b0), .lamp_sense_in(ind ^ lamp_cut),
        .safety_switching_outputs_out(safe),
        .mute_indicator_output_out(ind),
        .indicator_status_output_a_out(sa),
        .indicator_status_output_b_out(sb),
        .fault_out(flt));

    smc_sensor_model partner (
        .closed_in(closed), .pulse_in(pulse), .sensor_out(sensor_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : hold

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_en_in   <= 1'b1;
        @(posedge sys_clk_in);
        wr_en_in   <= 1'b0;
    endtask : reg_wr

    // the expected word is queued when the read is issued
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        rd_en_in <= 1'b1;
        exp_q.push_back(d);
        @(posedge sys_clk_in);
        rd_en_in <= 1'b0;
    endtask : reg_rd

    // bounded wait for the indicator; a timeout ends the run
    task automatic wait_ind(input logic exp);
        int i;
        for (i = 0; i < 600 && ind !== exp; i++)
            @(posedge sys_clk_in);
        check("mute_ind", 16'(ind), 16'(exp));
        if (ind !== exp)
            complete_run();
    endtask : wait_ind

    // one sensor stuck alone past the window, then a permit restart
    task automatic simul(input logic exp);
        closed <= 4'h1;
        hold(31000);
        permit <= 1'b0;
        hold(5000);
        permit <= 1'b1;
        hold(300);
        closed <= 4'h3;
        hold(600);
        check("mute_ind", 16'(ind), 16'(exp));
    endtask : simul

    // read data are looked at only in the cycle after the strobe
    always @(posedge sys_clk_in) begin
        rd_pend <= rd_en_in;
        if (rd_pend)
            check("rd_data", rd_data_out, exp_q.pop_front());
    end

    // watchdog keeps a hung run from going on for ever
    initial begin
        hold(100000);
        n_errors++;
        complete_run();
    end

    initial begin
        seed = 32'h3A8E;
        n_errors = 0;
        cmp_count = 0;
        rst_n_in = 1'b0;
        addr_in = 4'h0;
        wr_data_in = 16'h0000;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        rd_pend = 1'b0;
        closed = 4'h0;
        permit = 1'b1;
        guard_in = 1'b1;
        stop = 1'b0;
        lamp_cut = 1'b0;
        hold(8);
        rst_n_in <= 1'b1;
        lim = 16'h0020 | 16'($random(seed) & 32'h1F);
        reg_rd(smc_pkg::OFS_CFG, smc_pkg::CFG_RESET);
        reg_rd(smc_pkg::OFS_LIMIT, smc_pkg::LIMIT_RESET);
        reg_rd(4'hC, 16'h0000);
        reg_wr(smc_pkg::OFS_STATUS, 16'hFFFF);
        reg_rd(smc_pkg::OFS_STATUS, 16'h00A0);
        reg_wr(smc_pkg::OFS_LIMIT, lim);
        reg_rd(smc_pkg::OFS_LIMIT, lim);
        reg_wr(smc_pkg::OFS_LIMIT, smc_pkg::LIMIT_RESET);
        // pair 0 together with permit closed mutes; permit drop is ignored
        closed <= 4'h3;
        wait_ind(1'b1);
        check("status_a", 16'(sa), 16'h0001);
        check("status_b", 16'(sb), 16'h0001);
        check("fault", 16'(flt), 16'h0000);
        permit <= 1'b0;
        guard_in <= 1'b0;
        hold(400);
        check("mute_ind", 16'(ind), 16'h0001);
        check("safety", 16'(safe), 16'h0001);
        closed <= 4'h1;
        wait_ind(1'b0);
        check("safety", 16'(safe), 16'h0000);
        // pair on while permit open must not mute
        guard_in <= 1'b1;
        closed <= 4'h3;
        hold(600);
        check("mute_ind", 16'(ind), 16'h0000);
        // sensors settle open first, else the permit would start a mute
        closed <= 4'h0;
        hold(600);
        permit <= 1'b1;
        simul(1'b1);
        // a stop ends the mute; sensor 1 of the pair opens before the stop clears
        stop <= 1'b1;
        wait_ind(1'b0);
        check("safety", 16'(safe), 16'h0000);
        closed <= 4'h1;
        hold(600);
        stop <= 1'b0;
        simul(1'b0);
        closed <= 4'h0;
        hold(600);
        // short limit ends the mute and drops outputs with guard off
        reg_wr(smc_pkg::OFS_LIMIT, lim);
        closed <= 4'h3;
        wait_ind(1'b1);
        guard_in <= 1'b0;
        hold(lim * 5);
        check("mute_ind", 16'(ind), 16'h0001);
        check("safety", 16'(safe), 16'h0001);
        hold(lim * 5 + 200);
        check("mute_ind", 16'(ind), 16'h0000);
        check("safety", 16'(safe), 16'h0000);
        // a failed lamp blocks the next mute and raises the fault
        closed <= 4'h0;
        hold(600);
        reg_wr(smc_pkg::OFS_CFG,
               smc_pkg::CFG_RESET | (16'h0001 << smc_pkg::CFG_LAMP_MON));
        lamp_cut <= 1'b1;
        hold(1100);
        closed <= 4'h3;
        hold(600);
        check("mute_ind", 16'(ind), 16'h0000);
        check("fault", 16'(flt), 16'h0001);
        complete_run();
    end
endmodule : tb_top

// *** verilog/smc_mute_ctrl.sv ***
`timescale 1ns/1ps

// Function
// - sensors form a first pair and an optional second pair, each redundant
// - dual 2/3-terminal: flag channel cross short persisting over 2 s
// - dual 3-terminal: test pulses detect a short to foreign power
// - current-sourcing dual sensors: no short detection performed
// - dual 4-terminal: detect cross shorts and foreign power shorts
// - complementary: cross short; 3-terminal also foreign power when closed
// - normal mute starts only with permit closed; opening it later has no effect
// - one sensor alone over three seconds fails simultaneity, no mute
// - permit closed-open-closed with one sensor on restarts the timer
// - one timer restart per mute cycle; rearm once all sensors open
// - indicator on status outputs; monitored failure blocks new mutes
// - duration timer starts when the pair meets simultaneity
// - expiry ends mute; off input drops outputs, manual reset if set
// - infinite duration setting disables the limit
// - power-up mute: permit, safety input on, exactly one pair closed
// - automatic power-up mode starts that mute at once
// - manual power-up mode starts it on the first system reset
// - while muted the guarded input state is ignored
// - a mute needs both sensors of a pair on within 3 s
// - mute ends on sensor open, stop, expiry, lockout or power loss
module smc_mute_ctrl #(
    parameter int TICK_CYCLES  = smc_pkg::TICK_CYCLES,
    parameter int PULSE_CYCLES = smc_pkg::PULSE_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [15:0] rd_data_out,
    // mute sensors and permit
    input  wire logic [3:0]  sensor_in,
    input  wire logic        mute_permit_input_in,
    output logic      [3:0]  test_pulse_out,
    // guarded input and system pins
    input  wire logic        guard_in,
    input  wire logic        stop_req_in,
    input  wire logic        lockout_in,
    input  wire logic        system_reset_in,
    input  wire logic        lamp_sense_in,
    // outputs
    output logic             safety_switching_outputs_out,
    output logic             mute_indicator_output_out,
    output logic             indicator_status_output_a_out,
    output logic             indicator_status_output_b_out,
    output logic             fault_out
);

    typedef enum logic [1:0] {
        PR_IDLE, PR_CLOSED, PR_ARMED, PR_OPEN
    } smc_permit_t;
    typedef enum logic {MS_IDLE, MS_MUTED} smc_mute_t;

    // synchronised pins
    logic [9:0] s;
    wire  [3:0] s_sens   = s[3:0];
    wire        s_permit = s[4];
    wire        s_guard  = s[5];
    wire        s_stop   = s[6];
    wire        s_lock   = s[7];
    wire        s_sysrst = s[8];
    wire        s_lamp   = s[9];

    smc_sync #(.WIDTH(10)) u_sync (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({lamp_sense_in, system_reset_in, lockout_in,
                    stop_req_in, guard_in, mute_permit_input_in,
                    sensor_in}),
        .q_out    (s)
    );

    logic [15:0] cfg;
    logic [15:0] limit;
    logic        sysrst_q;

    // configuration decode
    wire [2:0] hook      = cfg[smc_pkg::CFG_HOOK +: 3];
    wire       two_pairs = cfg[smc_pkg::CFG_TWO_PAIRS];
    wire       pu_en     = cfg[smc_pkg::CFG_PU_EN];
    wire       pu_manual = cfg[smc_pkg::CFG_PU_MANUAL];
    wire       pu_permit = cfg[smc_pkg::CFG_PU_PERMIT];
    wire       lamp_mon  = cfg[smc_pkg::CFG_LAMP_MON];
    wire       man_reset = cfg[smc_pkg::CFG_MAN_RESET];
    wire       limit_inf = cfg[smc_pkg::CFG_LIMIT_INF];
    wire       current_sourcing_output       = (hook == smc_pkg::HK_DUAL_PNP) ||
                           (hook == smc_pkg::HK_COMP_PNP);
    wire       comp      = (hook == smc_pkg::HK_COMP_2T) ||
                           (hook == smc_pkg::HK_COMP_3T) ||
                           (hook == smc_pkg::HK_COMP_PNP);
    wire       foreign_chk = (hook == smc_pkg::HK_DUAL_3T) ||
                             (hook == smc_pkg::HK_DUAL_4T) ||
                             (hook == smc_pkg::HK_COMP_3T);
    wire       slow_cross  = (hook == smc_pkg::HK_DUAL_2T) ||
                             (hook == smc_pkg::HK_DUAL_3T);
    wire [1:0] pair_en     = {two_pairs, 1'b1};
    wire       sysrst_pulse = s_sysrst & ~sysrst_q;

    // millisecond time base
    logic [14:0] tick_cnt;
    wire         tick = (tick_cnt == 15'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) tick_cnt <= 15'h0000;
        else tick_cnt <= tick ? 15'h0000 : tick_cnt + 15'h0001;
    end

    // test pulse phases: all high, each channel low in turn, all low
    logic [2:0] phase;
    logic [7:0] ph_cnt;
    wire        ph_end  = (ph_cnt == 8'(PULSE_CYCLES - 1));
    wire [2:0]  next_phase = (phase == smc_pkg::PH_ALL_LOW) ?
                             smc_pkg::PH_ALL_HIGH : phase + 3'h1;
    wire [3:0]  pulse_pat  = (phase == smc_pkg::PH_ALL_HIGH) ? 4'hF :
                             (phase == smc_pkg::PH_ALL_LOW)  ? 4'h0 :
                             ~(4'h1 << (phase - 3'h1));

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase          <= 3'h0;
            ph_cnt         <= 8'h00;
            test_pulse_out <= 4'hF;
        end else begin
            ph_cnt         <= ph_end ? 8'h00 : ph_cnt + 8'h01;
            phase          <= ph_end ? next_phase : phase;
            test_pulse_out <= current_sourcing_output ? 4'hF : pulse_pat;
        end
    end

    // sensor state: sampled in the all-high phase, two equal samples
    logic [3:0] last_samp;
    logic [3:0] sens;
    logic       sens_valid;
    wire        samp_now = ph_end && (phase == smc_pkg::PH_ALL_HIGH);
    wire [3:0]  norm = sens ^ (comp ? smc_pkg::COMP_MASK : 4'h0);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_samp  <= 4'h0;
            sens       <= 4'h0;
            sens_valid <= 1'b0;
        end else if (samp_now) begin
            last_samp <= s_sens;
            if (s_sens == last_samp) begin
                sens       <= s_sens;
                sens_valid <= 1'b1;
            end
        end
    end

    // per-channel short evidence from the pulse phases
    logic [3:0] xev;
    logic [3:0] fev;

    for (genvar c = 0; c < 4; c++) begin : g_chan
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                xev[c] <= 1'b0;
                fev[c] <= 1'b0;
            end else if (ph_end) begin
                // own pulse low yet input high: fed by another channel
                if (phase == 3'(c + 1))
                    xev[c] <= s_sens[c] & ~current_sourcing_output;
                // everything low yet input high: foreign supply
                if (phase == smc_pkg::PH_ALL_LOW)
                    fev[c] <= s_sens[c] & foreign_chk &
                              ((hook != smc_pkg::HK_COMP_3T) | sens[c]);
            end
        end
    end

    // per-pair cross short timing and simultaneity
    logic [11:0] xs_cnt   [2];
    logic [11:0] sim_cnt  [2];
    logic [1:0]  fail_q;
    logic [1:0]  one_on;
    logic [1:0]  both_on;
    logic [1:0]  xshort;
    logic        perm_reset;

    for (genvar p = 0; p < 2; p++) begin : g_pair
        wire xp = xev[2*p] | xev[2*p+1] |
                  (comp & sens[2*p] & sens[2*p+1]);
        assign one_on[p]  = norm[2*p] ^ norm[2*p+1];
        assign both_on[p] = norm[2*p] & norm[2*p+1];
        // the slow hookups must see the short for the full window
        assign xshort[p]  = xp & (~slow_cross |
                            (xs_cnt[p] == smc_pkg::XSHORT_MS));

        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                xs_cnt[p]  <= 12'h000;
                sim_cnt[p] <= 12'h000;
                fail_q[p]  <= 1'b0;
            end else begin
                if (!xp)
                    xs_cnt[p] <= 12'h000;
                else if (tick && xs_cnt[p] != smc_pkg::XSHORT_MS)
                    xs_cnt[p] <= xs_cnt[p] + 12'h001;
                if (!one_on[p] || perm_reset)
                    sim_cnt[p] <= 12'h000;
                else if (tick && sim_cnt[p] != smc_pkg::SIMUL_MS)
                    sim_cnt[p] <= sim_cnt[p] + 12'h001;
                if ((norm[2*p+1:2*p] == 2'b00) || perm_reset)
                    fail_q[p] <= 1'b0;
                else if (one_on[p] && sim_cnt[p] == smc_pkg::SIMUL_MS)
                    fail_q[p] <= 1'b1;
            end
        end
    end

    // permit closed-open-closed tracker
    smc_permit_t pr_state;
    smc_permit_t next_pr;
    logic [11:0] pr_cnt;
    logic        armed;
    wire         pr_min = (pr_cnt > smc_pkg::PERMIT_MIN_MS);
    wire         pr_max = (pr_cnt > smc_pkg::PERMIT_MAX_MS);
    wire         cycle_ok = (pr_state == PR_OPEN) && s_permit && pr_min;

    assign perm_reset = cycle_ok & armed & |(one_on & pair_en);

    always_comb begin
        next_pr = pr_state;
        case (pr_state)
            PR_IDLE:   if (s_permit) next_pr = PR_CLOSED;
            PR_CLOSED: if (!s_permit) next_pr = PR_IDLE;
                       else if (pr_min) next_pr = PR_ARMED;
            PR_ARMED:  if (!s_permit) next_pr = PR_OPEN;
            PR_OPEN:   if (s_permit) next_pr = PR_CLOSED;
                       else if (pr_max) next_pr = PR_IDLE;
            default:   next_pr = PR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pr_state <= PR_IDLE;
            pr_cnt   <= 12'h000;
            armed    <= 1'b1;
        end else begin
            pr_state <= next_pr;
            if (next_pr != pr_state)
                pr_cnt <= 12'h000;
            else if (tick && !pr_max)
                pr_cnt <= pr_cnt + 12'h001;
            if (norm == 4'h0)
                armed <= 1'b1;
            else if (perm_reset)
                armed <= 1'b0;
        end
    end

    // fault flags, sticky until a system reset finds them gone
    logic        short_fault;
    logic        lamp_fault;
    logic [11:0] lamp_cnt;
    wire         short_now = |(xshort & pair_en) | |fev;
    wire         lamp_bad  = lamp_mon & (s_lamp != mute_indicator_output_out);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            short_fault <= 1'b0;
            lamp_fault  <= 1'b0;
            lamp_cnt    <= 12'h000;
            sysrst_q    <= 1'b0;
        end else begin
            sysrst_q <= s_sysrst;
            if (!lamp_bad)
                lamp_cnt <= 12'h000;
            else if (tick && lamp_cnt != smc_pkg::LAMP_MS)
                lamp_cnt <= lamp_cnt + 12'h001;
            // set wins over the reset that would clear it
            if (short_now)
                short_fault <= 1'b1;
            else if (sysrst_pulse)
                short_fault <= 1'b0;
            if (lamp_cnt == smc_pkg::LAMP_MS)
                lamp_fault <= 1'b1;
            else if (sysrst_pulse)
                lamp_fault <= 1'b0;
        end
    end

    // mute start and hold conditions
    smc_mute_t   mstate;
    logic [15:0] dur_cnt;
    logic        pu_pending;
    logic        need_rst;
    logic        spent;
    wire muted    = (mstate == MS_MUTED);
    wire start_ok = sens_valid & ~lamp_fault & ~short_fault &
                    ~s_lock & ~s_stop & ~spent;
    wire norm_start = |(both_on & ~fail_q & pair_en) & s_permit;
    wire one_pair = (both_on[0] ^ (both_on[1] & two_pairs));
    wire pu_eval  = pu_pending & sens_valid &
                    (~pu_manual | sysrst_pulse);
    wire pu_start = pu_eval & pu_en & (s_permit | ~pu_permit) &
                    s_guard & one_pair;
    wire limit_hit = ~limit_inf & (dur_cnt >= limit);
    wire keep = |(both_on & pair_en) & ~s_stop & ~s_lock &
                ~short_fault & ~limit_hit;
    wire guard_ok = muted | s_guard;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mstate     <= MS_IDLE;
            dur_cnt    <= 16'h0000;
            pu_pending <= 1'b1;
            spent      <= 1'b0;
        end else begin
            if (pu_eval || !pu_en)
                pu_pending <= 1'b0;
            // an expired mute must not restart on the same sensor cycle
            if (muted && limit_hit)
                spent <= 1'b1;
            else if (norm == 4'h0)
                spent <= 1'b0;
            case (mstate)
                MS_IDLE: if (start_ok && (norm_start || pu_start)) begin
                    mstate  <= MS_MUTED;
                    dur_cnt <= 16'h0000;
                end
                MS_MUTED: if (!keep) mstate <= MS_IDLE;
                else if (tick && !limit_hit) dur_cnt <= dur_cnt + 16'h0001;
                default: mstate <= MS_IDLE;
            endcase
        end
    end

    // safety outputs and mute indicators
    wire drop = ~guard_ok | s_stop | s_lock | short_fault;
    wire next_need = man_reset &
                     (need_rst | (safety_switching_outputs_out & drop)) &
                     ~(sysrst_pulse & ~drop);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            need_rst                      <= 1'b1;
            safety_switching_outputs_out  <= 1'b0;
            mute_indicator_output_out     <= 1'b0;
            indicator_status_output_a_out <= 1'b0;
            indicator_status_output_b_out <= 1'b0;
            fault_out                     <= 1'b0;
        end else begin
            need_rst                      <= next_need;
            safety_switching_outputs_out  <= ~drop & ~next_need;
            mute_indicator_output_out     <= muted;
            indicator_status_output_a_out <= muted;
            indicator_status_output_b_out <= muted;
            fault_out                     <= short_fault | lamp_fault;
        end
    end

    // register port: writes steer, reads show state one cycle later
    wire [15:0] status = {4'h0, norm, armed, pu_pending,
                          safety_switching_outputs_out, fail_q,
                          short_fault, lamp_fault, muted};
    wire [15:0] rd_mux = (addr_in == smc_pkg::OFS_CFG)    ? cfg :
                         (addr_in == smc_pkg::OFS_LIMIT)  ? limit :
                         (addr_in == smc_pkg::OFS_STATUS) ? status :
                         16'h0000;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg         <= smc_pkg::CFG_RESET;
            limit       <= smc_pkg::LIMIT_RESET;
            rd_data_out <= 16'h0000;
        end else begin
            if (wr_en_in && addr_in == smc_pkg::OFS_CFG)
                cfg <= wr_data_in;
            if (wr_en_in && addr_in == smc_pkg::OFS_LIMIT)
                limit <= wr_data_in;
            rd_data_out <= rd_en_in ? rd_mux : 16'h0000;
        end
    end

    a_start_permit: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(muted) && !$past(pu_start) |-> $past(s_permit))
        else $error("mute began without permit");

    a_fail_blocks: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        fail_q[0] && !both_on[1] && !muted && !pu_start |=> !muted)
        else $error("mute began after simultaneity failure");

    a_reset_once: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        perm_reset |=> !armed ##1 (!perm_reset || norm == 4'h0))
        else $error("second timer restart in one cycle");

    a_lamp_blocks: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        lamp_fault && !muted |=> !muted)
        else $error("mute began with indicator failed");

    a_limit_ends: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        muted && limit_hit |=> !muted ##1 !mute_indicator_output_out)
        else $error("mute outlived its limit");

    a_pnp_quiet: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        current_sourcing_output && $stable(hook) |=> test_pulse_out == 4'hF)
        else $error("pulses driven in current-sourcing mode");

    a_muted_runs: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        muted && !s_stop && !s_lock && !short_fault && !need_rst
        && !man_reset |=> safety_switching_outputs_out)
        else $error("muted guarded input caused a stop");

    a_sim_window: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(fail_q[0]) |-> $past(sim_cnt[0]) == smc_pkg::SIMUL_MS)
        else $error("simultaneity failed early");

    a_cross_wait: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(short_fault) && slow_cross && !$past(|fev) |->
        $past(xs_cnt[0]) == smc_pkg::XSHORT_MS ||
        $past(xs_cnt[1]) == smc_pkg::XSHORT_MS)
        else $error("cross short flagged before its window");

endmodule : smc_mute_ctrl

// *** verilog/smc_pkg.sv ***
package smc_pkg;

    // clock and the millisecond time base used by every mute window
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

    // windows in milliseconds, as figures
    localparam logic [11:0] SIMUL_MS      = 12'hBB8; // 3000 ms
    localparam logic [11:0] PERMIT_MIN_MS = 12'h0FA; // 250 ms
    localparam logic [11:0] PERMIT_MAX_MS = 12'h7D0; // 2000 ms
    localparam logic [11:0] XSHORT_MS     = 12'h7D0; // 2000 ms
    localparam logic [11:0] LAMP_MS       = 12'h064; // 100 ms settle

    // test pulse phase length in clock cycles, and phase numbering
    localparam int         PULSE_CYCLES = 100;
    localparam logic [2:0] PH_ALL_HIGH  = 3'h0;
    localparam logic [2:0] PH_ALL_LOW   = 3'h5;

    // register offsets
    localparam logic [3:0] OFS_CFG    = 4'h0;
    localparam logic [3:0] OFS_LIMIT  = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // configuration field positions
    localparam int CFG_HOOK      = 0; // three bits
    localparam int CFG_TWO_PAIRS = 3;
    localparam int CFG_PU_EN     = 4;
    localparam int CFG_PU_MANUAL = 5;
    localparam int CFG_PU_PERMIT = 6;
    localparam int CFG_LAMP_MON  = 7;
    localparam int CFG_MAN_RESET = 8;
    localparam int CFG_LIMIT_INF = 9;

    // reset values
    localparam logic [15:0] CFG_RESET   = 16'h0008;
    localparam logic [15:0] LIMIT_RESET = 16'h2710; // 10000 ms

    // hookup codes
    localparam logic [2:0] HK_DUAL_2T   = 3'h0;
    localparam logic [2:0] HK_DUAL_3T   = 3'h1;
    localparam logic [2:0] HK_DUAL_PNP  = 3'h2;
    localparam logic [2:0] HK_DUAL_4T   = 3'h3;
    localparam logic [2:0] HK_COMP_2T   = 3'h4;
    localparam logic [2:0] HK_COMP_3T   = 3'h5;
    localparam logic [2:0] HK_COMP_PNP  = 3'h6;

    // second channel of each pair is inverted in complementary hookups
    localparam logic [3:0] COMP_MASK = 4'hA;

endpackage : smc_pkg

// *** verilog/smc_sync.sv ***
`timescale 1ns/1ps

// two flip-flop synchroniser for pin inputs
module smc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end

endmodule : smc_sync
